// ---- dtp_pkg.sv ----
// Constants and types shared by the dead-time PWM waveform block
// Assumes one 50 MHz APB clock drives counter, sync and delay logic
package dtp_pkg;

    localparam int CNT_W = 12;
    localparam int ADDR_W = 8;
    localparam int DLY_W = 8;
    localparam int EVC_W = 4;
    localparam int IM_W = 4;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_EVA = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_EVB = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_INA = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_INB = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_DLYCTL = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_DELAY_VALUE = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_ASET = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_ACLR = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_BSET = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_BCLR = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h2C;
    localparam logic [ADDR_W-1:0] OFS_CAPA = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_CAPB = 8'h34;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CTRL_EN = 0;
    localparam int CTRL_WG = 1;
    localparam int EV_TRIG = 0;
    localparam int EV_ACT = 1;
    localparam int EV_FILT = 2;
    localparam int EV_ASYNCHRONOUS_DETECT_BIT = 3;
    localparam int DLY_SEL = 0;
    localparam int DLY_TRIG = 2;
    localparam int DLY_PRESC = 4;
    localparam int ST_STATE = 0;
    localparam int ST_OUTA = 2;
    localparam int ST_OUTB = 3;
    localparam int ST_BLANK = 4;
    localparam int ST_CNT = 16;

    ////////////////////////////////////////////////////////////////////////
    // Encodings and reset values
    localparam logic [1:0] WG_ONE = 2'h0;
    localparam logic [1:0] WG_TWO = 2'h1;
    localparam logic [1:0] WG_FOUR = 2'h2;
    localparam logic [1:0] WG_DUAL = 2'h3;
    localparam logic [IM_W-1:0] IM_STOP_ALL = 4'h4;
    localparam logic [IM_W-1:0] IM_STOP_EDGE = 4'h9;
    localparam logic [1:0] DSEL_BLANK = 2'h1;
    localparam logic [1:0] DTRIG_SET_A = 2'h0;
    localparam logic [1:0] DTRIG_CLR_A = 2'h1;
    localparam logic [1:0] DTRIG_SET_B = 2'h2;
    localparam logic [1:0] DTRIG_CLR_B = 2'h3;
    localparam int FILT_LEN = 4;
    localparam logic [CNT_W-1:0] CMP_RST = 12'h000;
    localparam logic [DLY_W-1:0] DLY_RST = 8'h00;
    localparam logic [EVC_W-1:0] EVC_RST = 4'h0;
    localparam logic [IM_W-1:0] IM_RST = 4'h0;

    typedef enum logic [1:0] {ST_DTA, ST_OTA, ST_DTB, ST_OTB} dtp_state_t;

endpackage : dtp_pkg

// ---- dtp_evt_if.sv ----
// Carrier between the timer core and one event input conditioner
// Assumes the core drives raw event and its enables
`timescale 1ns/1ns
interface dtp_evt_if;
    logic raw;
    logic trig_en;
    logic filt_en;
    logic ev;
    modport src (output raw, output trig_en, output filt_en, input ev);
    modport cond (input raw, input trig_en, input filt_en, output ev);
endinterface : dtp_evt_if

// ---- dtp_evt_in.sv ----
// Event input conditioner: optional digital filter and sync stages
// Assumes raw event is synchronous to pclk
`timescale 1ns/1ns
module dtp_evt_in
    import dtp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    dtp_evt_if.cond e
);

    logic [FILT_LEN-1:0] hist;
    logic filt;
    logic stage1;
    logic stage2;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////
    // Filter: level changes after FILT_LEN equal samples
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hist <= '0;
        else
            hist <= {hist[FILT_LEN-2:0], e.raw};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            filt <= 1'b0;
        else if (&hist)
            filt <= 1'b1;
        else if (~|hist)
            filt <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Two sync stages before processing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end
        else
        begin
            stage1 <= e.filt_en ? filt : e.raw;
            stage2 <= stage1;
        end
    end

    assign e.ev = stage2 & e.trig_en;

    a_sync_delay: assert property (
        $past(presetn, 2) && !$past(e.filt_en, 2)
        |-> e.ev == ($past(e.raw, 2) && e.trig_en))
        else $error("event not seen two cycles after input");

    a_filter_min: assert property (
        $rose(e.ev) && $past(e.trig_en) && $past(e.filt_en, 2)
        && $past(e.filt_en, 3)
        |-> $past(e.raw, 4) && $past(e.raw, 5) && $past(e.raw, 6)
        && $past(e.raw, 7))
        else $error("filtered event passed a short pulse");

endmodule : dtp_evt_in

// ---- dtp_top.sv ----
// Dead-time PWM waveform generator with two event inputs, APB slave
// Assumes event inputs synchronous to pclk; counter runs on pclk
`timescale 1ns/1ns
module dtp_top
    import dtp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic event_a,
    input wire logic event_b,
    output logic output_a,
    output logic output_b
);

    logic en;
    logic [1:0] wg;
    logic [EVC_W-1:0] evc [2];
    logic [IM_W-1:0] imode [2];
    logic [1:0] dsel;
    logic [1:0] dtrig;
    logic [1:0] dpresc;
    logic [DLY_W-1:0] delay_value;
    logic [CNT_W-1:0] aset;
    logic [CNT_W-1:0] aclr;
    logic [CNT_W-1:0] bset;
    logic [CNT_W-1:0] bclr;
    logic [CNT_W-1:0] cap [2];
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    dtp_state_t state;
    dtp_state_t next_state;
    logic up;
    logic next_up;
    logic first;
    logic set_a;
    logic clr_a;
    logic set_b;
    logic clr_b;
    logic cyc_end;
    logic wa;
    logic wb;
    logic [1:0] wout;
    logic [1:0] raw;
    logic [1:0] ev;
    logic [1:0] ev_use;
    logic [1:0] ev_q;
    logic [1:0] ev_rise;
    logic [1:0] kill;
    logic [1:0] stop_sel;
    logic [1:0] asynchronous_detect_bit_hit;
    logic stop_all;
    logic blank;
    logic [DLY_W-1:0] dly_cnt;
    logic [2:0] pre_cnt;
    logic [2:0] pre_mask;
    logic dly_tick;
    logic dly_hit;
    logic [31:0] rd_val;
    logic rd_err;
    logic wr;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait-free access phase
    assign pready = psel & penable;
    assign wr = psel & penable & pwrite;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr <= rd_err;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en <= 1'b0;
            wg <= WG_ONE;
            evc <= '{EVC_RST, EVC_RST};
            imode <= '{IM_RST, IM_RST};
            dsel <= 2'h0;
            dtrig <= 2'h0;
            dpresc <= 2'h0;
            delay_value <= DLY_RST;
            aset <= CMP_RST;
            aclr <= CMP_RST;
            bset <= CMP_RST;
            bclr <= CMP_RST;
        end
        else if (wr)
        begin
            case (paddr)
                OFS_CTRL:
                begin
                    en <= pwdata[CTRL_EN];
                    if (!en)
                        wg <= pwdata[CTRL_WG+:2];
                end
                OFS_EVA: evc[0] <= pwdata[EVC_W-1:0];
                OFS_EVB: evc[1] <= pwdata[EVC_W-1:0];
                OFS_INA: imode[0] <= pwdata[IM_W-1:0];
                OFS_INB: imode[1] <= pwdata[IM_W-1:0];
                OFS_DLYCTL:
                begin
                    dsel <= pwdata[DLY_SEL+:2];
                    dtrig <= pwdata[DLY_TRIG+:2];
                    dpresc <= pwdata[DLY_PRESC+:2];
                end
                OFS_DELAY_VALUE: delay_value <= pwdata[DLY_W-1:0];
                OFS_ASET: aset <= pwdata[CNT_W-1:0];
                OFS_ACLR: aclr <= pwdata[CNT_W-1:0];
                OFS_BSET: bset <= pwdata[CNT_W-1:0];
                OFS_BCLR: bclr <= pwdata[CNT_W-1:0];
                default:
                begin
                end
            endcase
        end
    end

    always_comb
    begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr)
            OFS_CTRL:
            begin
                rd_val[CTRL_EN] = en;
                rd_val[CTRL_WG+:2] = wg;
            end
            OFS_EVA: rd_val[EVC_W-1:0] = evc[0];
            OFS_EVB: rd_val[EVC_W-1:0] = evc[1];
            OFS_INA: rd_val[IM_W-1:0] = imode[0];
            OFS_INB: rd_val[IM_W-1:0] = imode[1];
            OFS_DLYCTL:
            begin
                rd_val[DLY_SEL+:2] = dsel;
                rd_val[DLY_TRIG+:2] = dtrig;
                rd_val[DLY_PRESC+:2] = dpresc;
            end
            OFS_DELAY_VALUE: rd_val[DLY_W-1:0] = delay_value;
            OFS_ASET: rd_val[CNT_W-1:0] = aset;
            OFS_ACLR: rd_val[CNT_W-1:0] = aclr;
            OFS_BSET: rd_val[CNT_W-1:0] = bset;
            OFS_BCLR: rd_val[CNT_W-1:0] = bclr;
            OFS_STATUS:
            begin
                rd_val[ST_STATE+:2] = state;
                rd_val[ST_OUTA] = output_a;
                rd_val[ST_OUTB] = output_b;
                rd_val[ST_BLANK] = blank;
                rd_val[ST_CNT+:CNT_W] = cnt;
            end
            OFS_CAPA: rd_val[CNT_W-1:0] = cap[0];
            OFS_CAPB: rd_val[CNT_W-1:0] = cap[1];
            default: rd_err = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare matches and counting pattern per mode
    always_comb
    begin
        next_cnt = cnt + 12'h001;
        next_up = up;
        set_a = 1'b0;
        clr_a = 1'b0;
        set_b = 1'b0;
        clr_b = 1'b0;
        cyc_end = 1'b0;
        unique case (wg)
            WG_ONE:
            begin
                set_a = cnt == aset;
                clr_a = cnt == aclr && aclr >= aset;
                set_b = cnt == bset;
                clr_b = cnt == bclr;
                cyc_end = clr_b;
                if (clr_b)
                    next_cnt = CMP_RST;
            end
            WG_TWO:
            begin
                if (state == ST_DTA || state == ST_OTA)
                begin
                    set_a = state == ST_DTA && cnt == aset;
                    clr_a = cnt == aclr;
                end
                else
                begin
                    set_b = state == ST_DTB && cnt == bset;
                    clr_b = cnt == bclr;
                end
                cyc_end = clr_b;
                if (clr_a || clr_b)
                    next_cnt = CMP_RST;
            end
            WG_FOUR:
            begin
                unique case (state)
                    ST_DTA: set_a = cnt == aset;
                    ST_OTA: clr_a = cnt == aclr;
                    ST_DTB: set_b = cnt == bset;
                    ST_OTB: clr_b = cnt == bclr;
                endcase
                cyc_end = clr_b;
                if (set_a || clr_a || set_b || clr_b)
                    next_cnt = CMP_RST;
            end
            WG_DUAL:
            begin
                if (up)
                begin
                    set_a = cnt == aset && !first;
                    clr_b = cnt == bset;
                    if (cnt == bclr)
                    begin
                        next_up = 1'b0;
                        next_cnt = cnt;
                        cyc_end = 1'b1;
                    end
                end
                else
                begin
                    clr_a = cnt == aset;
                    set_b = cnt == bset;
                    next_cnt = cnt - 12'h001;
                    if (cnt == CMP_RST)
                    begin
                        next_up = 1'b1;
                        next_cnt = cnt;
                    end
                end
            end
        endcase
    end

    always_comb
    begin
        next_state = state;
        if (set_a)
            next_state = ST_OTA;
        if (clr_a)
            next_state = ST_DTB;
        if (set_b)
            next_state = ST_OTB;
        if (clr_b)
            next_state = ST_DTA;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= CMP_RST;
            state <= ST_DTA;
            up <= 1'b0;
            first <= 1'b1;
        end
        else if (!en)
        begin
            cnt <= (wg == WG_DUAL) ? bclr : CMP_RST;
            state <= ST_DTA;
            up <= 1'b0;
            first <= 1'b1;
        end
        else
        begin
            cnt <= next_cnt;
            state <= next_state;
            up <= next_up;
            if (cyc_end)
                first <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Waveform outputs, clear wins over set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wa <= 1'b0;
            wb <= 1'b0;
        end
        else if (!en)
        begin
            wa <= 1'b0;
            wb <= 1'b0;
        end
        else
        begin
            if (clr_a)
                wa <= 1'b0;
            else if (set_a)
                wa <= 1'b1;
            if (clr_b)
                wb <= 1'b0;
            else if (set_b)
                wb <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event inputs
    dtp_evt_if ev_a_if ();
    dtp_evt_if ev_b_if ();

    assign raw = {event_b, event_a};
    assign ev_a_if.raw = event_a;
    assign ev_b_if.raw = event_b;
    assign ev_a_if.trig_en = evc[0][EV_TRIG];
    assign ev_b_if.trig_en = evc[1][EV_TRIG];
    assign ev_a_if.filt_en = evc[0][EV_FILT];
    assign ev_b_if.filt_en = evc[1][EV_FILT];
    assign ev = {ev_b_if.ev, ev_a_if.ev};

    dtp_evt_in u_evt_a (
        .pclk(pclk),
        .presetn(presetn),
        .e(ev_a_if.cond)
    );

    dtp_evt_in u_evt_b (
        .pclk(pclk),
        .presetn(presetn),
        .e(ev_b_if.cond)
    );

    assign ev_use = ev & {1'b1, ~blank};
    assign ev_rise = ev_use & ~ev_q;
    assign wout = {wb, wa};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ev_q <= 2'b00;
        else
            ev_q <= ev_use;
    end

    // Reaction per input; reserved codes take no action
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            stop_sel[i] = imode[i] == IM_STOP_ALL;
            asynchronous_detect_bit_hit[i] = raw[i] & evc[i][EV_TRIG] & evc[i][EV_ASYNCHRONOUS_DETECT_BIT]
                & ~evc[i][EV_FILT] & stop_sel[i];
        end
        asynchronous_detect_bit_hit[0] = asynchronous_detect_bit_hit[0] & ~blank;
    end

    assign stop_all = |(ev_use & stop_sel) | |asynchronous_detect_bit_hit;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            kill <= 2'b00;
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (ev_rise[i] && imode[i] == IM_STOP_EDGE && wout[i])
                    kill[i] <= 1'b1;
                else if (!wout[i])
                    kill[i] <= 1'b0;
            end
        end
    end

    assign output_a = wa & ~stop_all & ~kill[0];
    assign output_b = wb & ~stop_all & ~kill[1];

    // Capture of counter on event edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cap <= '{CMP_RST, CMP_RST};
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (ev_rise[i] && evc[i][EV_ACT])
                    cap[i] <= cnt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input A blanking on the shared delay logic
    always_comb
    begin
        unique case (dpresc)
            2'h0: pre_mask = 3'h0;
            2'h1: pre_mask = 3'h1;
            2'h2: pre_mask = 3'h3;
            2'h3: pre_mask = 3'h7;
        endcase
        unique case (dtrig)
            DTRIG_SET_A: dly_hit = set_a;
            DTRIG_CLR_A: dly_hit = clr_a;
            DTRIG_SET_B: dly_hit = set_b;
            DTRIG_CLR_B: dly_hit = clr_b;
        endcase
    end

    assign dly_tick = (pre_cnt & pre_mask) == pre_mask;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            blank <= 1'b0;
            dly_cnt <= DLY_RST;
            pre_cnt <= 3'h0;
        end
        else if (en && dsel == DSEL_BLANK && dly_hit && delay_value != DLY_RST)
        begin
            blank <= 1'b1;
            dly_cnt <= DLY_RST;
            pre_cnt <= 3'h0;
        end
        else if (!en || dsel != DSEL_BLANK)
            blank <= 1'b0;
        else if (blank)
        begin
            pre_cnt <= pre_cnt + 3'h1;
            if (dly_tick)
            begin
                if (dly_cnt + 8'h01 == delay_value)
                    blank <= 1'b0;
                else
                    dly_cnt <= dly_cnt + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_one_wrap: assert property (
        en && wg == WG_ONE && cnt == bclr |=> cnt == CMP_RST)
        else $error("one ramp did not wrap at b clear");

    a_one_step: assert property (
        en && wg == WG_ONE && cnt != bclr
        |=> !en || cnt == $past(cnt) + 12'h001)
        else $error("one ramp did not count up");

    a_four_first: assert property (
        en && wg == WG_FOUR && state == ST_DTA && cnt == aset
        |=> !en || (state == ST_OTA && cnt == CMP_RST && wa))
        else $error("four ramp missed a set restart");

    a_two_overlap: assert property (
        en && wg == WG_TWO |-> !(wa && wb))
        else $error("two ramp outputs overlap");

    a_dual_start: assert property (
        $rose(en) && wg == WG_DUAL && $stable(wg) && $stable(bclr)
        |-> cnt == bclr && !up)
        else $error("dual slope did not start at b clear");

    a_dual_first: assert property (
        en && wg == WG_DUAL && first |-> !wa)
        else $error("output a set during first dual cycle");

    a_stop_all: assert property (
        ev_use[0] && imode[0] == IM_STOP_ALL
        |-> !output_a && !output_b)
        else $error("stop-all event left an output on");

    a_blank_hold: assert property (
        blank && en && dsel == DSEL_BLANK
        && ({1'b0, dly_cnt} + 9'h001 < {1'b0, delay_value}) |=> blank)
        else $error("blanking ended before delay value");

endmodule : dtp_top

// ---- dtp_evt_src.sv ----
// Event routing model feeding the two event inputs
// Assumes requests change just after a rising pclk edge
`timescale 1ns/1ns
module dtp_evt_src
(
    input wire logic [1:0] req,
    output logic event_a,
    output logic event_b
);
    ////////////////////////////////////////////////////////////
    // Level events routed straight to inputs A and B
    assign event_a = req[0];
    assign event_b = req[1];
endmodule : dtp_evt_src

// ---- test_dead_time_pwm_waveform_inputs.sv ----
// Self-checking bench for the dead-time PWM waveform block
// Assumes dtp_top with zero-wait APB and the event routing model
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
$display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_dead_time_pwm_waveform_inputs
    import dtp_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic event_a;
    logic event_b;
    logic output_a;
    logic output_b;
    logic [1:0] rq = 2'b00;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    typedef struct {
        logic [1:0] m;
        logic [11:0] c [4];
        logic [3:0] ev;
        logic [3:0] im;
        logic bl;
        logic [1:0] rq;
        int p;
        int na;
        int nb;
    } dtp_row_t;
    // Mode, compares, event ctl, input mode, blank, events, pulse, a, b
    dtp_row_t rows [12] = '{
        '{0, '{0, 1, 2, 3}, 0, 0, 0, 0, 0, 10, 10},
        '{0, '{5, 6, 2, 3}, 0, 0, 0, 0, 0, 0, 10},
        '{1, '{1, 3, 1, 3}, 0, 0, 0, 0, 0, 10, 10},
        '{2, '{1, 2, 1, 2}, 0, 0, 0, 0, 0, 12, 12},
        '{3, '{2, 7, 1, 4}, 0, 0, 0, 0, 0, 20, 12},
        '{0, '{0, 1, 2, 3}, 1, 4, 0, 2, 0, 0, 0},
        '{0, '{0, 1, 2, 3}, 0, 4, 0, 3, 0, 10, 10},
        '{0, '{0, 1, 2, 3}, 5, 4, 0, 2, 0, 0, 0},
        '{0, '{0, 1, 2, 3}, 5, 4, 0, 2, 3, 10, 10},
        '{0, '{0, 1, 2, 3}, 9, 4, 0, 1, 0, 0, 0},
        '{0, '{0, 1, 2, 3}, 1, 4, 1, 1, 0, 10, 10},
        '{0, '{0, 30, 31, 39}, 1, 9, 0, 1, 2, 15, 8}};
    always #10 pclk = ~pclk;
    dtp_top dtp_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .event_a(event_a), .event_b(event_b), .output_a(output_a),
        .output_b(output_b));
    dtp_evt_src dtp_evt_src_i (.req(rq), .event_a(event_a),
        .event_b(event_b));
    ////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic run(input dtp_row_t r);
        int na = 0;
        int nb = 0;
        int nab = 0;
        int pre = 0;
        wr(OFS_CTRL, 32'h0000_0000);
        for (int k = 0; k < 4; k++)
            wr(OFS_ASET + ADDR_W'(4 * k), 32'(r.c[k]));
        wr(OFS_EVA, 32'(r.ev));
        wr(OFS_EVB, 32'(r.ev));
        wr(OFS_INA, 32'(r.im));
        wr(OFS_INB, 32'(r.im));
        wr(OFS_DLYCTL, 32'(r.bl));
        wr(OFS_DELAY_VALUE, r.bl ? 32'h0000_00FF : 32'h0000_0000);
        wr(OFS_CTRL, {29'h0, r.m, 1'b0});
        rq <= (r.p == 0) ? r.rq : 2'b00;
        wr(OFS_CTRL, {29'h0, r.m, 1'b1});
        for (int i = 0; i < 12; i++)
        begin
            @(negedge pclk);
            if (i < 10 && output_a !== 1'b0)
                pre++;
        end
        for (int i = 0; i < 40; i++)
        begin
            @(posedge pclk);
            if (r.p != 0 && i == 0)
                rq <= r.rq;
            if (r.p != 0 && i == r.p)
                rq <= 2'b00;
            @(negedge pclk);
            na += (output_a !== 1'b0);
            nb += (output_b !== 1'b0);
            nab += (output_a !== 1'b0 && output_b !== 1'b0);
        end
        @(posedge pclk);
        rq <= 2'b00;
        if (r.m == 2'd3)
            `CHK(pre, 0)
        `CHK(na, r.na)
        `CHK(nb, r.nb)
        `CHK(nab, 0)
    endtask : run
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            errors++;
            test_done;
        end
    end
    initial
    begin
        logic [31:0] q;
        logic e;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int n = 0; n < 12; n++)
        begin
            run(rows[n]);
            $display("row %0d done", n);
        end
        wr(OFS_ASET, 32'h0000_1ABC);
        apb(1'b0, OFS_ASET, 32'h0, q, e);
        `CHK(q, 32'h0000_0ABC)
        apb(1'b0, 8'h3C, 32'h0, q, e);
        `CHK({e, q}, 33'h1_0000_0000)
        $display("register test done");
        wr(OFS_CTRL, 32'h0000_0001);
        repeat (5) @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        `CHK({output_a, output_b}, 2'b00)
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_ASET, 32'h0, q, e);
        `CHK(q, 32'h0000_0000)
        $display("reset test done");
        test_done;
    end
endmodule : test_dead_time_pwm_waveform_inputs
